// ---- src/dma_tc_channel_status.v ----
`timescale 1ns/1ps
`include "tc_status_regs.vh"
module dma_tc_channel_status
(
  input wire clk,
  input wire reset_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg avs_response_err,
  input wire transfer_request_valid,
  input wire src_done,
  input wire head_done,
  input wire write_issued,
  input wire write_status_returned,
  output reg program_set_busy,
  output reg source_set_active,
  output reg transfer_request_start
);
// ************************************************************
// state
// ************************************************************
reg [2:0] dest_fifo_occupancy;
reg [1:0] dest_fifo_head_offset;
reg [7:0] ws_count;
reg write_status_pending;
reg [1:0] dest_fifo_depth_code;
reg [2:0] depth_entries;
reg fifo_full;
reg can_move;
reg move;
reg pop;
reg [1:0] next_head;
reg [31:0] status_word;
reg [31:0] next_readdata;
// ************************************************************
// depth decode and transfer gating
// ************************************************************
always @*
begin
  case (dest_fifo_depth_code)
    `DEPTH_CODE_1: depth_entries = 3'h1;
    `DEPTH_CODE_2: depth_entries = 3'h2;
    `DEPTH_CODE_4: depth_entries = `FIFO_MAX;
    default: depth_entries = `FIFO_MAX;
  endcase
  fifo_full = (dest_fifo_occupancy >= depth_entries);
  pop = head_done && (dest_fifo_occupancy != 3'h0);
  // head wraps at the configured depth; a four-entry FIFO wraps by itself
  case (dest_fifo_depth_code)
    `DEPTH_CODE_1: next_head = 2'h0;
    `DEPTH_CODE_2: next_head = {1'b0, ~dest_fifo_head_offset[0]};
    default: next_head = dest_fifo_head_offset + 2'h1;
  endcase
  if (dest_fifo_occupancy == 3'h0)
    can_move = 1'b1;
  else if (!fifo_full)
    can_move = !source_set_active;
  else
    can_move = 1'b0;
  move = program_set_busy && can_move;
end
// ************************************************************
// program set, source set, destination FIFO
// ************************************************************
always @(posedge clk or negedge reset_n)
begin
  if (!reset_n)
  begin
    program_set_busy <= 1'b0;
    source_set_active <= 1'b0;
    transfer_request_start <= 1'b0;
    dest_fifo_occupancy <= 3'h0;
    dest_fifo_head_offset <= 2'h0;
  end
  else
  begin
    transfer_request_start <= move;
    // new request latched only when idle; controller holds it otherwise
    if (move)
      program_set_busy <= 1'b0;
    else if (transfer_request_valid && !program_set_busy)
      program_set_busy <= 1'b1;
    // the source set picks up the moved request; done wins no race with a new move
    if (move)
      source_set_active <= 1'b1;
    else if (src_done)
      source_set_active <= 1'b0;
    if (move && !pop)
      dest_fifo_occupancy <= dest_fifo_occupancy + 3'h1;
    else if (pop && !move)
      dest_fifo_occupancy <= dest_fifo_occupancy - 3'h1;
    if (pop)
      dest_fifo_head_offset <= next_head;
  end
end
// ************************************************************
// write status tracking
// ************************************************************
always @(posedge clk or negedge reset_n)
begin
  if (!reset_n)
  begin
    ws_count <= 8'h00;
    write_status_pending <= 1'b0;
  end
  else
  begin
    // counter saturates; issue and return in one cycle cancel out
    if (write_issued && !write_status_returned && ws_count != `WS_CNT_MAX)
    begin
      ws_count <= ws_count + 8'h01;
      write_status_pending <= 1'b1;
    end
    else if (write_status_returned && !write_issued && ws_count != 8'h00)
    begin
      ws_count <= ws_count - 8'h01;
      write_status_pending <= (ws_count != 8'h01);
    end
  end
end
// ************************************************************
// avalon slave: status read-only, depth code writable
// ************************************************************
always @*
begin
  status_word = `TC_STATUS_RESET;
  status_word[`BIT_PROG_BUSY] = program_set_busy;
  status_word[`BIT_SRC_ACTIVE] = source_set_active;
  status_word[`BIT_WS_PENDING] = write_status_pending;
  status_word[`OCC_MSB:`OCC_LSB] = dest_fifo_occupancy;
  status_word[`HEAD_MSB:`HEAD_LSB] = dest_fifo_head_offset;
  next_readdata = 32'h0000_0000;
  if (avs_address == `TC_STATUS_ADDR)
    next_readdata = status_word;
  else if (avs_address == `TC_CONFIG_ADDR)
    next_readdata[`DEPTH_MSB:`DEPTH_LSB] = dest_fifo_depth_code;
end
always @(posedge clk or negedge reset_n)
begin
  if (!reset_n)
  begin
    avs_readdata <= 32'h0000_0000;
    avs_waitrequest <= 1'b1;
    avs_response_err <= 1'b0;
    dest_fifo_depth_code <= `DEPTH_CODE_4;
  end
  else
  begin
    // one wait cycle per access: waitrequest drops for a single cycle
    avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_response_err <= (avs_address != `TC_STATUS_ADDR) &&
                          (avs_address != `TC_CONFIG_ADDR);
      if (avs_read)
        avs_readdata <= next_readdata;
      // depth changes only while the FIFO is empty to keep the pointer valid
      if (avs_write && avs_address == `TC_CONFIG_ADDR && avs_byteenable[1] &&
          dest_fifo_occupancy == 3'h0 && avs_writedata[`DEPTH_MSB:`DEPTH_LSB] != 2'h3)
        dest_fifo_depth_code <= avs_writedata[`DEPTH_MSB:`DEPTH_LSB];
    end
  end
end
endmodule // dma_tc_channel_status

// ---- include/tc_status_regs.vh ----
// Operation
// - report head entry position in entries
// - report destination FIFO occupancy count zero to four
// - occupancy four is full at depth four
// - empty FIFO takes programmed request immediately
// - partly full takes request only if source idle
// - full FIFO holds requests back
// - full clears only when head request completes
// - write status pending while writes outstanding
// - source active bit shows servicing
// - program busy bit shows set occupied
// - status word read-only with reset values
// - depth code: 0=1,1=2,2=4,3 reserved
`ifndef TC_STATUS_REGS_VH
`define TC_STATUS_REGS_VH
// ************************************************************
// register map
// ************************************************************
`define TC_STATUS_ADDR 4'h0
`define TC_CONFIG_ADDR 4'h4
`define TC_STATUS_RESET 32'h0000_0000
// ************************************************************
// field positions
// ************************************************************
`define BIT_PROG_BUSY 0
`define BIT_SRC_ACTIVE 1
`define BIT_WS_PENDING 2
`define OCC_LSB 4
`define OCC_MSB 6
`define HEAD_LSB 11
`define HEAD_MSB 12
`define DEPTH_LSB 8
`define DEPTH_MSB 9
// ************************************************************
// depth codes and limits
// ************************************************************
`define DEPTH_CODE_1 2'h0
`define DEPTH_CODE_2 2'h1
`define DEPTH_CODE_4 2'h2
`define FIFO_MAX 3'h4
`define WS_CNT_MAX 8'hFF
`endif

// ---- verif/tc_status_monitor.sv ----
`timescale 1ns/1ps
`include "tc_status_regs.vh"
module tc_status_monitor
(
  input wire clk,
  input wire reset_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire avs_response_err,
  input wire transfer_request_valid,
  input wire program_set_busy,
  input wire source_set_active,
  input wire transfer_request_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [31:0] q = avs_readdata;
  wire sa = avs_read && !avs_waitrequest && avs_address == `TC_STATUS_ADDR;
  property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_busy; $rose(program_set_busy) |-> $past(transfer_request_valid); endproperty
  a_busy: assert property (p_busy) else $error("busy without request");
  property p_st; transfer_request_start |-> source_set_active && !program_set_busy; endproperty
  a_st: assert property (p_st) else $error("bad move");
  property p_src; $rose(source_set_active) |-> transfer_request_start; endproperty
  a_src: assert property (p_src) else $error("source set without move");
  property p_pls; transfer_request_start |=> !transfer_request_start; endproperty
  a_pls: assert property (p_pls) else $error("move pulse too long");
  property p_occ; sa |-> q[6:4] < 3'h5; endproperty
  a_occ: assert property (p_occ) else $error("occupancy code");
  property p_rsv; sa |-> q[31:13] == 0 && q[10:7] == 0 && !q[3]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_err; avs_read && !avs_waitrequest && avs_address == 4'h8 |-> q == 0; endproperty
  a_err: assert property (p_err) else $error("unmapped data");
  c_mv: cover property (transfer_request_start);
  c_err: cover property (avs_response_err);
  c_idle: cover property ($fell(source_set_active));
endmodule // tc_status_monitor
bind dma_tc_channel_status tc_status_monitor mon (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response_err(avs_response_err), .transfer_request_valid(transfer_request_valid),
  .program_set_busy(program_set_busy), .source_set_active(source_set_active),
  .transfer_request_start(transfer_request_start));

// ---- verif/tc_ctrl_model.sv ----
`timescale 1ns/1ps
module tc_ctrl_model
(
  input wire clk,
  input wire reset_n,
  input wire go,
  input wire program_set_busy,
  output logic transfer_request_valid
);
  // request held until busy is seen, so it is never taken twice
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      transfer_request_valid <= 1'b0;
    else if (program_set_busy)
      transfer_request_valid <= 1'b0;
    else if (go)
      transfer_request_valid <= 1'b1;
endmodule // tc_ctrl_model

// ---- verif/dma_tc_channel_status_test.sv ----
`timescale 1ns/1ps
`include "tc_status_regs.vh"
module dma_tc_channel_status_test;
  logic clk = 0, reset_n = 0, go = 0, avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = 0, ev = 0;
  logic [31:0] avs_writedata = 0, rdv;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, avs_response_err, trv, busy, src, start;
  int error_cnt = 0, checks_done = 0;
  always #20 clk = ~clk;
  dma_tc_channel_status dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .transfer_request_valid(trv), .src_done(ev[0]),
    .head_done(ev[1]), .write_issued(ev[2]), .write_status_returned(ev[3]),
    .program_set_busy(busy), .source_set_active(src), .transfer_request_start(start));
  tc_ctrl_model ctrl (.clk(clk), .reset_n(reset_n), .go(go), .program_set_busy(busy),
    .transfer_request_valid(trv));
  task stop_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task chk(input logic [3:0] a, input logic [31:0] e);
    acc(0, a, 0);
    cmp("readdata", e, rdv);
  endtask
  task req;
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (4) @(posedge clk);
  endtask
  task pls(input logic [3:0] v);
    ev <= v;
    @(posedge clk);
    ev <= 0;
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1;
    chk(`TC_STATUS_ADDR, `TC_STATUS_RESET);
    chk(`TC_CONFIG_ADDR, 32'h0000_0200);
    acc(1, `TC_STATUS_ADDR, 32'hFFFF_FFFF);
    chk(`TC_STATUS_ADDR, 32'h0);
    chk(4'h8, 32'h0);
    @(posedge clk);
    cmp("err", 32'h1, {31'h0, avs_response_err});
    req;
    chk(0, 32'h12);
    req;
    chk(0, 32'h13);
    pls(4'h1);
    chk(0, 32'h22);
    repeat (2)
    begin
      pls(4'h1);
      req;
    end
    chk(0, 32'h42);
    pls(4'h1);
    chk(0, 32'h40);
    req;
    chk(0, 32'h41);
    pls(4'h2);
    chk(0, 32'h842);
    pls(4'h4);
    chk(0, 32'h846);
    pls(4'h8);
    chk(0, 32'h842);
    acc(1, `TC_CONFIG_ADDR, 32'h0000_0100);
    chk(`TC_CONFIG_ADDR, 32'h0000_0200);
    stop_test;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
endmodule // dma_tc_channel_status_test
